/* include/irq_seq_pkg.sv */
// Functional notes
// RULE1: A source vectors only if its own enable and global enable are set.
// RULE2: Reset vector is address zero; lower vector index wins arbitration.
// RULE3: Accepting an interrupt clears the global enable bit.
// RULE4: Global enable set inside a handler lets pending requests nest.
// RULE5: Return-from-interrupt sets the global enable bit.
// RULE6: Vectoring to a flag source clears that source's flag.
// RULE7: Writing one to a flag position clears it; zero leaves it.
// RULE8: Flag events set and hold the flag even while disabled.
// RULE9: Held flags are served one by one in priority order.
// RULE10: Level sources request only while their condition is present.
// RULE11: One interrupted instruction runs after return before the next entry.
// RULE12: Status register is neither saved on entry nor restored on return.
// RULE13: Clearing global enable blocks an interrupt arriving in that same cycle.
// RULE14: The instruction after setting global enable runs before any entry.
// RULE15: Entry lasts four cycles, pushes program counter, then loads vector.
// RULE16: The jump held at a vector takes three cycles in the core.
// RULE17: Entry waits until a multi-cycle instruction has fully completed.
// RULE18: Entry from sleep takes four extra cycles.
// RULE19: Return takes four cycles, pops two bytes, adds two to stack pointer.
// RULE20: Program counter is 10, 11 or 12 bits wide.
// RULE21: Entry push decrements the stack pointer by two.
// RULE22: Global enable lives in bit 7 of the status register.
// RULE23: Requests are arbitrated at instruction boundaries, winner registered first.
// RULE24: Reset starts execution at address zero with global enable clear.
package irq_seq_pkg;

	// Status register layout
	localparam int          GIE_BIT            = 7;
	localparam logic        GIE_RESET          = 1'b0;

	// Cycle counts of the sequences
	localparam int          CNT_W              = 4;
	localparam logic [3:0]  ENTRY_CYCLES       = 4'h4;
	localparam logic [3:0]  SLEEP_EXTRA_CYCLES = 4'h4;
	localparam logic [3:0]  RETURN_CYCLES      = 4'h4;
	localparam logic [3:0]  JUMP_CYCLES        = 4'h3;

	// Vector table and stack
	localparam int          RESET_VECTOR       = 0;
	localparam int          VECTOR_BASE        = 1;
	localparam logic [15:0] SP_PUSH_STEP       = 16'h0002;
	localparam logic [15:0] SP_RESET           = 16'h025F;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_ENTRY  = 2'b01,
		ST_RETURN = 2'b10
	} seq_state_t;

	// Stack memory request, one byte per cycle
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} stack_req_t;

endpackage : irq_seq_pkg

/* core/irq_priority_pick.sv */
`timescale 1ns/1ps
// Fixed priority pick: lowest index among requests wins
module irq_priority_pick #(
	parameter int NUM_SRC = 8,
	parameter int IDX_W   = 3
) (
	input  wire logic [NUM_SRC-1:0] req_i,
	output logic                    valid_o,
	output logic [IDX_W-1:0]        idx_o
);

	// Scan from the top so the lowest set index is left standing
	always_comb begin
		valid_o = 1'b0;
		idx_o   = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				valid_o = 1'b1;
				idx_o   = IDX_W'(i); // RULE2
			end
		end
	end

endmodule : irq_priority_pick

/* core/cpu_interrupt_sequencer.sv */
`timescale 1ns/1ps
// Interrupt gating, arbitration, entry and return sequencing for the core
module cpu_interrupt_sequencer #(
	parameter int          NUM_SRC   = 8,
	parameter int          PC_W      = 12,
	parameter logic [NUM_SRC-1:0] FLAG_MASK = '1
) (
	input  wire logic                      clock_i,
	input  wire logic                      rst_i,
	// Execution core
	input  wire logic                      instr_done_i,
	input  wire logic                      op_sei_i,
	input  wire logic                      op_cli_i,
	input  wire logic                      op_return_i,
	input  wire logic                      status_wr_i,
	input  wire logic [7:0]                status_wdata_i,
	input  wire logic                      sleeping_i,
	input  wire logic [PC_W-1:0]           pc_i,
	input  wire logic                      sp_wr_i,
	input  wire logic [15:0]               sp_wdata_i,
	// Peripheral sources
	input  wire logic [NUM_SRC-1:0]        flag_set_i,
	input  wire logic                      flag_clr_wr_i,
	input  wire logic [NUM_SRC-1:0]        flag_clr_data_i,
	input  wire logic [NUM_SRC-1:0]        src_en_i,
	input  wire logic [NUM_SRC-1:0]        level_req_i,
	// Stack memory
	input  wire logic [7:0]                stack_rdata_i,
	output irq_seq_pkg::stack_req_t        stack_o,
	// Results
	output logic                           gie_o,
	output logic [NUM_SRC-1:0]             flags_o,
	output logic [NUM_SRC-1:0]             ack_o,
	output logic                           pc_load_o,
	output logic [PC_W-1:0]                pc_target_o,
	output logic                           core_hold_o,
	output logic [15:0]                    sp_o
);

	localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

	irq_seq_pkg::seq_state_t           state;
	logic [irq_seq_pkg::CNT_W-1:0]     cnt;
	logic                              gie;
	logic [NUM_SRC-1:0]                flags;
	logic [NUM_SRC-1:0]                req;
	logic                              arb_valid;
	logic [IDX_W-1:0]                  arb_idx;
	logic [IDX_W-1:0]                  win_idx;
	logic                              asleep;
	logic [PC_W-1:0]                   ret_pc;
	logic [7:0]                        pop_hi;
	logic [15:0]                       sp;
	logic                              cli_now;
	logic                              take;
	logic                              entry_last;
	logic                              return_last;
	logic [irq_seq_pkg::CNT_W-1:0]     entry_len;
	logic [NUM_SRC-1:0]                hw_clr;
	logic [NUM_SRC-1:0]                next_flags;
	logic [15:0]                       ret_pc_w;
	irq_seq_pkg::stack_req_t           stack_req;
	logic                              pc_load;
	logic [PC_W-1:0]                   pc_target;
	logic                              core_hold;
	logic [NUM_SRC-1:0]                ack;

	// Widen the saved return address to two bytes
	function automatic logic [15:0] pc_to_word(input logic [PC_W-1:0] pc);
		logic [15:0] w;
		w = '0;
		w[PC_W-1:0] = pc; // RULE20
		return w;
	endfunction : pc_to_word

	// Vector address of a source, reset vector sits below all of them
	function automatic logic [PC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
		logic [PC_W-1:0] v;
		v = PC_W'(irq_seq_pkg::VECTOR_BASE) + PC_W'(idx); // RULE2
		return v;
	endfunction : vector_of

	// Per-source request: flags for event sources, live level otherwise
	generate
		for (genvar g = 0; g < NUM_SRC; g++) begin : g_req
			if (FLAG_MASK[g]) begin : g_flag
				assign req[g] = flags[g] & src_en_i[g]; // RULE1
			end else begin : g_level
				assign req[g] = level_req_i[g] & src_en_i[g]; // RULE10
			end
		end
	endgenerate

	irq_priority_pick #(
		.NUM_SRC (NUM_SRC),
		.IDX_W   (IDX_W)
	) u_pick (
		.req_i   (req),
		.valid_o (arb_valid),
		.idx_o   (arb_idx)
	);

	// Global enable being cleared in this very cycle
	assign cli_now = op_cli_i | (status_wr_i & ~status_wdata_i[irq_seq_pkg::GIE_BIT]); // RULE13

	// Acceptance only at a boundary or from sleep, with global enable set.
	// Global enable is a register, so the cycle of a set instruction never
	// takes; the following instruction completes first.
	assign take = (state == irq_seq_pkg::ST_RUN) & arb_valid & gie & ~cli_now // RULE1 RULE13 RULE14
		& (instr_done_i | sleeping_i) & ~op_return_i; // RULE17 RULE23

	// Entry length grows when waking from sleep
	assign entry_len = asleep ? (irq_seq_pkg::ENTRY_CYCLES + irq_seq_pkg::SLEEP_EXTRA_CYCLES)
		: irq_seq_pkg::ENTRY_CYCLES; // RULE15 RULE18
	assign entry_last  = (state == irq_seq_pkg::ST_ENTRY)
		& (cnt == entry_len - irq_seq_pkg::CNT_W'(1));
	assign return_last = (state == irq_seq_pkg::ST_RETURN)
		& (cnt == irq_seq_pkg::RETURN_CYCLES - irq_seq_pkg::CNT_W'(1)); // RULE19

	assign ret_pc_w = pc_to_word(ret_pc);

	// Hardware clears the flag of the source being vectored to
	always_comb begin
		hw_clr = '0;
		if (take) begin
			hw_clr[arb_idx] = FLAG_MASK[arb_idx]; // RULE6
		end
	end

	// New events win over either kind of clear
	always_comb begin
		next_flags = flags & ~hw_clr;
		if (flag_clr_wr_i) begin
			next_flags = next_flags & ~flag_clr_data_i; // RULE7
		end
		next_flags = (next_flags | flag_set_i) & FLAG_MASK; // RULE8 RULE9
	end

	// Pending flags, held regardless of enables
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			flags <= '0;
		end else begin
			flags <= next_flags; // RULE8
		end
	end

	// Sequencer state and cycle counter
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= irq_seq_pkg::ST_RUN;
			cnt   <= '0;
		end else begin
			unique case (state)
				irq_seq_pkg::ST_RUN: begin
					cnt <= '0;
					if (take) begin
						state <= irq_seq_pkg::ST_ENTRY;
					end else if (op_return_i) begin
						state <= irq_seq_pkg::ST_RETURN;
					end
				end
				irq_seq_pkg::ST_ENTRY: begin
					cnt <= cnt + irq_seq_pkg::CNT_W'(1);
					if (entry_last) begin
						state <= irq_seq_pkg::ST_RUN; // RULE15
						cnt   <= '0;
					end
				end
				irq_seq_pkg::ST_RETURN: begin
					cnt <= cnt + irq_seq_pkg::CNT_W'(1);
					if (return_last) begin
						state <= irq_seq_pkg::ST_RUN; // RULE11
						cnt   <= '0;
					end
				end
				default: begin
					state <= irq_seq_pkg::ST_RUN;
					cnt   <= '0;
				end
			endcase
		end
	end

	// Winner, return address and sleep state caught at acceptance
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			win_idx <= '0;
			ret_pc  <= '0;
			asleep  <= 1'b0;
		end else if (take) begin
			win_idx <= arb_idx; // RULE23
			ret_pc  <= pc_i;
			asleep  <= sleeping_i; // RULE18
		end
	end

	// Global enable bit of the status register; other bits untouched here
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			gie <= irq_seq_pkg::GIE_RESET; // RULE24
		end else if (take) begin
			gie <= 1'b0; // RULE3
		end else if (return_last) begin
			gie <= 1'b1; // RULE5
		end else if (cli_now) begin
			gie <= 1'b0; // RULE13
		end else if (op_sei_i) begin
			gie <= 1'b1; // RULE4 RULE14
		end else if (status_wr_i) begin
			gie <= status_wdata_i[irq_seq_pkg::GIE_BIT]; // RULE22
		end
	end

	// Stack pointer: software load, minus two on entry, plus two on return
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sp <= irq_seq_pkg::SP_RESET;
		end else if ((state == irq_seq_pkg::ST_ENTRY) && (cnt == irq_seq_pkg::CNT_W'(1))) begin
			sp <= sp - irq_seq_pkg::SP_PUSH_STEP; // RULE21
		end else if (return_last) begin
			sp <= sp + irq_seq_pkg::SP_PUSH_STEP; // RULE19
		end else if (sp_wr_i) begin
			sp <= sp_wdata_i;
		end
	end

	// Stack requests: low byte pushed first, high byte popped first
	always_comb begin
		stack_req = '0;
		if (state == irq_seq_pkg::ST_ENTRY) begin
			if (cnt == '0) begin
				stack_req.wr    = 1'b1;
				stack_req.addr  = sp;
				stack_req.wdata = ret_pc_w[7:0]; // RULE15
			end else if (cnt == irq_seq_pkg::CNT_W'(1)) begin
				stack_req.wr    = 1'b1;
				stack_req.addr  = sp - 16'h0001;
				stack_req.wdata = ret_pc_w[15:8];
			end
		end else if (state == irq_seq_pkg::ST_RETURN) begin
			if (cnt == '0) begin
				stack_req.rd   = 1'b1;
				stack_req.addr = sp + 16'h0001; // RULE19
			end else if (cnt == irq_seq_pkg::CNT_W'(1)) begin
				stack_req.rd   = 1'b1;
				stack_req.addr = sp + irq_seq_pkg::SP_PUSH_STEP;
			end
		end
	end

	// High byte of the popped address, read data lags its request by two cycles
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pop_hi <= '0;
		end else if ((state == irq_seq_pkg::ST_RETURN) && (cnt == irq_seq_pkg::CNT_W'(2))) begin
			pop_hi <= stack_rdata_i;
		end
	end

	// Program counter load: vector after entry, popped value after return
	always_comb begin
		pc_load   = 1'b0;
		pc_target = '0;
		if (entry_last) begin
			pc_load   = 1'b1;
			pc_target = vector_of(win_idx); // RULE15 RULE16
		end else if (return_last) begin
			pc_load   = 1'b1;
			pc_target = PC_W'({pop_hi, stack_rdata_i}); // RULE20
		end
	end

	// Core is held from acceptance or return until the load
	always_comb begin
		core_hold = 1'b0;
		if (take || (op_return_i && state == irq_seq_pkg::ST_RUN)) begin
			core_hold = 1'b1;
		end else if (state != irq_seq_pkg::ST_RUN) begin
			core_hold = !(entry_last || return_last);
		end
	end

	// One-hot acknowledge towards the accepted source
	always_comb begin
		ack = '0;
		if (take) begin
			ack[arb_idx] = 1'b1;
		end
	end

	// Registered outputs; reset loads address zero into the core
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stack_o     <= '0;
			pc_load_o   <= 1'b1; // RULE24
			pc_target_o <= PC_W'(irq_seq_pkg::RESET_VECTOR);
			core_hold_o <= 1'b0;
			ack_o       <= '0;
		end else begin
			stack_o     <= stack_req;
			pc_load_o   <= pc_load;
			pc_target_o <= pc_target;
			core_hold_o <= core_hold;
			ack_o       <= ack;
		end
	end

	// Status outputs follow their registers
	assign gie_o   = gie; // RULE12
	assign flags_o = flags;
	assign sp_o    = sp;

endmodule : cpu_interrupt_sequencer

/* bench/stack_ram_model.sv */
`timescale 1ns/1ps
// Stack memory: one byte per request, read data one cycle after the read
module stack_ram_model (
	input  wire logic                    clock_i,
	input  wire irq_seq_pkg::stack_req_t stack_i,
	output logic [7:0]                   rdata_o
);
	logic [7:0] mem [256];
	initial rdata_o = 8'h00;
	// Idle read data flips every cycle so stale bytes never look valid
	always @(posedge clock_i) begin
		if (stack_i.wr)
			mem[stack_i.addr[7:0]] <= stack_i.wdata;
		rdata_o <= stack_i.rd ? mem[stack_i.addr[7:0]] : ~rdata_o;
	end
endmodule : stack_ram_model

/* bench/cpu_interrupt_sequencer_sva.sv */
`timescale 1ns/1ps
// Port checks on entry, return and gating
module cpu_interrupt_sequencer_sva #(
	parameter int NUM_SRC = 8
) (
	input wire logic                    clock_i,
	input wire logic                    rst_i,
	input wire logic                    op_cli_i,
	input wire logic                    op_return_i,
	input wire logic                    sleeping_i,
	input wire logic [NUM_SRC-1:0]      src_en_i,
	input wire logic [NUM_SRC-1:0]      flag_set_i,
	input wire irq_seq_pkg::stack_req_t stack_o,
	input wire logic                    gie_o,
	input wire logic [NUM_SRC-1:0]      flags_o,
	input wire logic [NUM_SRC-1:0]      ack_o,
	input wire logic                    pc_load_o,
	input wire logic                    core_hold_o,
	input wire logic [15:0]             sp_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	logic taken;
	// Any acknowledge marks the first entry cycle
	assign taken = (ack_o != '0);
	// Two byte push, two byte pop
	sequence push_s;
		stack_o.wr ##1 stack_o.wr;
	endsequence
	sequence pop_s;
		core_hold_o && stack_o.rd ##1 stack_o.rd;
	endsequence
	chk_gated_take: assert property (
		taken |-> $past(gie_o) && ((ack_o & ~$past(src_en_i)) == '0))
		else $error("take without enables");
	chk_take_gie: assert property (
		taken |-> !gie_o) else $error("gie still set after take");
	chk_cli_blocks: assert property (
		op_cli_i |=> !taken) else $error("take in cli cycle");
	chk_entry_walk: assert property (
		taken && !$past(sleeping_i) |-> ##1 push_s ##2 pc_load_o)
		else $error("entry walk wrong");
	chk_sleep_wait: assert property (
		taken && $past(sleeping_i) |-> !pc_load_o [*8] ##1 pc_load_o)
		else $error("sleep entry latency wrong");
	chk_push_sp: assert property (
		taken && !$past(sleeping_i) |-> ##2 sp_o == $past(sp_o, 2) - 16'h0002)
		else $error("push step wrong");
	chk_flag_cleared: assert property (
		taken && $past(flag_set_i) == '0 |-> (flags_o & ack_o) == '0)
		else $error("flag kept after take");
	chk_return_walk: assert property (
		op_return_i && !core_hold_o |-> ##2 pop_s ##2 pc_load_o && gie_o)
		else $error("return walk wrong");
	chk_return_sp: assert property (
		op_return_i && !core_hold_o |-> ##5 sp_o == $past(sp_o, 5) + 16'h0002)
		else $error("pop step wrong");
endmodule : cpu_interrupt_sequencer_sva
bind cpu_interrupt_sequencer cpu_interrupt_sequencer_sva #(.NUM_SRC(NUM_SRC)) u_sva (
	.clock_i(clock_i), .rst_i(rst_i), .op_cli_i(op_cli_i), .op_return_i(op_return_i),
	.sleeping_i(sleeping_i), .src_en_i(src_en_i), .flag_set_i(flag_set_i),
	.stack_o(stack_o), .gie_o(gie_o), .flags_o(flags_o), .ack_o(ack_o),
	.pc_load_o(pc_load_o), .core_hold_o(core_hold_o), .sp_o(sp_o)
);

/* bench/cpu_interrupt_sequencer_tb.sv */
`timescale 1ns/1ps
// Sequencer bench driven as the core and peripherals
module cpu_interrupt_sequencer_tb;
	logic clock_i = 1'b0, rst_i = 1'b1, instr_done_i = 1'b0, op_sei_i = 1'b0, op_cli_i = 1'b0;
	logic op_return_i = 1'b0, status_wr_i = 1'b0, sleeping_i = 1'b0, sp_wr_i = 1'b0;
	logic flag_clr_wr_i = 1'b0, gie_o, pc_load_o, core_hold_o;
	logic [7:0] flag_set_i = 8'h00, flag_clr_data_i = 8'h00, src_en_i = 8'h00;
	logic [7:0] level_req_i = 8'h00, status_wdata_i = 8'h00, stack_rdata_i, flags_o, ack_o;
	logic [11:0] pc_i = 12'hABC, pc_target_o;
	logic [15:0] sp_wdata_i = 16'h025F, sp_o;
	irq_seq_pkg::stack_req_t stack_o;
	int failures = 0, check_count = 0;
	always #25 clock_i = ~clock_i;
	cpu_interrupt_sequencer #(.FLAG_MASK(8'hFE)) u_dut (
		.clock_i(clock_i), .rst_i(rst_i), .instr_done_i(instr_done_i), .op_sei_i(op_sei_i),
		.op_cli_i(op_cli_i), .op_return_i(op_return_i), .status_wr_i(status_wr_i),
		.status_wdata_i(status_wdata_i), .sleeping_i(sleeping_i), .pc_i(pc_i), .sp_wr_i(sp_wr_i),
		.sp_wdata_i(sp_wdata_i), .flag_set_i(flag_set_i), .flag_clr_wr_i(flag_clr_wr_i),
		.flag_clr_data_i(flag_clr_data_i), .src_en_i(src_en_i), .level_req_i(level_req_i),
		.stack_rdata_i(stack_rdata_i), .stack_o(stack_o), .gie_o(gie_o), .flags_o(flags_o),
		.ack_o(ack_o), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
		.core_hold_o(core_hold_o), .sp_o(sp_o)
	);
	stack_ram_model u_ram (.clock_i(clock_i), .stack_i(stack_o), .rdata_o(stack_rdata_i));
	task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp
	task automatic test_done();
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	// One instruction completes with op pulses {sei, cli, return_from_interrupt_op}
	task automatic instr(input logic [2:0] ops);
		{op_sei_i, op_cli_i, op_return_i} = ops;
		instr_done_i = 1'b1;
		@(negedge clock_i);
		{op_sei_i, op_cli_i, op_return_i, instr_done_i} = 4'h0;
	endtask : instr
	// Wait for an entry, check winner and vector load
	task automatic take(input int idx, input int lat);
		int n = 0;
		while (ack_o === 8'h00 && n < 12) begin
			@(negedge clock_i);
			n++;
		end
		cmp("ack", 16'h0001 << idx, ack_o);
		cmp("gie", 16'h0000, gie_o);
		repeat (lat) @(negedge clock_i);
		cmp("load", 16'h0001, pc_load_o);
		cmp("vector", 16'(idx + 1), pc_target_o);
	endtask : take
	// Return: popped address, gie back on, stack pointer restored
	task automatic do_return(input logic [11:0] addr);
		int n = 0;
		instr(3'b001);
		while (pc_load_o !== 1'b1 && n < 8) begin
			@(negedge clock_i);
			n++;
		end
		cmp("ret_pc", addr, pc_target_o);
		cmp("gie", 16'h0001, gie_o);
		cmp("sp", 16'h025F, sp_o);
	endtask : do_return
	initial begin
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		cmp("gie", 16'h0000, gie_o);
		cmp("target", 16'h0000, pc_target_o);
		flag_set_i = 8'h26;
		@(negedge clock_i);
		flag_set_i = 8'h00;
		flag_clr_wr_i = 1'b1;
		flag_clr_data_i = 8'h02;
		@(negedge clock_i);
		flag_clr_wr_i = 1'b0;
		cmp("flags", 16'h0024, flags_o);
		src_en_i = 8'h25;
		instr(3'b000);
		cmp("ack", 16'h0000, ack_o);
		instr(3'b100);
		cmp("ack", 16'h0000, ack_o);
		instr(3'b000);
		take(2, 4);
		pc_i = 12'h123;
		cmp("flags", 16'h0020, flags_o);
		cmp("sp", 16'h025D, sp_o);
		do_return(12'hABC);
		repeat (3) @(negedge clock_i);
		cmp("ack", 16'h0000, ack_o);
		instr(3'b000);
		take(5, 4);
		flag_set_i = 8'h04;
		@(negedge clock_i);
		flag_set_i = 8'h00;
		instr(3'b100);
		instr(3'b010);
		cmp("ack", 16'h0000, ack_o);
		instr(3'b100);
		instr(3'b000);
		take(2, 4);
		src_en_i = 8'h24;
		level_req_i = 8'h01;
		instr(3'b100);
		level_req_i = 8'h00;
		src_en_i = 8'h25;
		instr(3'b000);
		cmp("ack", 16'h0000, ack_o);
		level_req_i = 8'h01;
		instr(3'b000);
		take(0, 4);
		level_req_i = 8'h00;
		instr(3'b100);
		sleeping_i = 1'b1;
		flag_set_i = 8'h20;
		@(negedge clock_i);
		flag_set_i = 8'h00;
		take(5, 8);
		sleeping_i = 1'b0;
		test_done();
	end
	// Watchdog well beyond the sequence length
	initial begin
		repeat (2000) @(posedge clock_i);
		failures++;
		test_done();
	end
endmodule : cpu_interrupt_sequencer_tb
